// ==== hdl/saw_regs.vh ====
`ifndef SAW_REGS_VH
`define SAW_REGS_VH
// register indices reached through the command byte
`define SAW_REG_MONTH      4'h7
`define SAW_REG_YEAR       4'h8
`define SAW_REG_LAST       4'hf
// command byte layout
`define SAW_CMD_RW_BIT     7
`define SAW_CMD_SA_HI      6
`define SAW_CMD_SA_LO      4
`define SAW_CMD_RA_HI      3
`define SAW_CMD_RA_LO      0
`define SAW_CMD_SA_VALID   3'h1
// register reset value
`define SAW_REG_RESET      8'h00
// timing: tick period in ns, core clock period in ns
`define SAW_TICK_PERIOD_NS 1000000000
`define SAW_CLK_PERIOD_NS  50
`define SAW_TICK_CYCLES    (`SAW_TICK_PERIOD_NS / `SAW_CLK_PERIOD_NS)
// watchdog trips on this many ticks after a valid sub-address
`define SAW_WD_TRIP_TICKS  2'h2
`endif

// ==== hdl/saw_watchdog.v ====
// How it works
// - time counters frozen during serial access
// - select low clears interface, releases counters
// - over one second after the command byte: self clear, resume
// - after abort ignore bus until select low
// - abort loses one tick, plus any that fall in the command byte
// - trip between one and two seconds
// - month then year via address advance
// - command byte: direction, sub-address 001, index
// - address increments per byte, wraps to zero
// - select low holds interface in reset
// - sample rising, shift out falling, msb first
`timescale 1ns/10ps
`default_nettype none
`include "saw_regs.vh"

module saw_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             core_clk,  // block clock
    input  wire             rst_n,     // sync reset, active low
    input  wire [WIDTH-1:0] in_data,   // word to store
    input  wire             in_valid,  // word offered
    output wire             in_ready,  // room left
    output wire [WIDTH-1:0] out_data,  // oldest word
    output wire             out_valid, // not empty
    input  wire             out_ready  // drain takes word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];   // flip-flop storage
    reg [AW-1:0]    wr_ptr;            // next slot to fill
    reg [AW-1:0]    rd_ptr;            // next slot to drain
    reg [AW:0]      fill;              // words held
    wire            push;
    wire            pop;

    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers wrap at depth; count tracks both ends
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                               {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end
endmodule

module saw_watchdog #(
    parameter TICK_CYCLES = `SAW_TICK_CYCLES  // core cycles per 1 Hz tick
) (
    input  wire        core_clk,        // 20 MHz block clock
    input  wire        rst_n,           // sync reset, active low
    input  wire        select_pin,      // chip enable, active high
    input  wire        sclk_pin,        // serial clock from host
    input  wire        serial_in_line,  // serial data in
    output reg         serial_out_line, // serial data out
    output reg         serial_out_en,   // high while driving out
    output reg         counters_frozen, // time counters held
    output reg  [15:0] seconds_count,   // elapsed time counter
    output reg         wd_abort,        // one-cycle pulse on trip
    output reg         write_dropped    // sticky: fifo was full
);
    localparam ST_IDLE = 3'h0;  // select low
    localparam ST_CMD  = 3'h1;  // shifting command byte
    localparam ST_DATA = 3'h2;  // data bytes after valid command
    localparam ST_IGN  = 3'h3;  // bad sub-address, ignore
    localparam ST_LOCK = 3'h4;  // after watchdog trip

    // two-stage synchronisers for every pin
    reg        sel_s1, sel_s2;
    reg        sck_s1, sck_s2, sck_d;
    reg        sdi_s1, sdi_s2;
    wire       sck_rise = sck_s2 & ~sck_d;
    wire       sck_fall = ~sck_s2 & sck_d;

    reg [2:0]  state;        // interface state
    reg [2:0]  bit_cnt;      // bits of current byte
    reg [7:0]  in_shift;     // received bits
    reg [7:0]  out_shift;    // bits to send
    reg        rd_mode;      // direction from command
    reg        load_pend;    // reload out_shift on next fall
    reg [3:0]  addr;         // register address counter
    reg [7:0]  regs [0:15];  // register file
    reg [24:0] tick_div;     // 1 Hz divider
    reg        tick;         // one-cycle 1 Hz pulse
    reg [1:0]  wd_ticks;     // ticks seen since valid command
    wire [7:0] next_byte = {in_shift[6:0], sdi_s2};
    wire       wd_trip;

    // fifo between serial receiver and register file
    reg        wr_valid;
    reg [11:0] wr_word;      // {address, data}
    wire       wr_ready;
    wire [11:0] fifo_word;
    wire       fifo_valid;
    wire       fifo_ready = ~tick;  // file busy on tick cycles

    saw_fifo #(.WIDTH(12), .DEPTH(4), .AW(2)) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_data   (wr_word),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (fifo_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // pins are asynchronous to core_clk
    always @(posedge core_clk) begin
        if (!rst_n) begin
            sel_s1 <= 1'b0; sel_s2 <= 1'b0;
            sck_s1 <= 1'b0; sck_s2 <= 1'b0; sck_d <= 1'b0;
            sdi_s1 <= 1'b0; sdi_s2 <= 1'b0;
        end else begin
            sel_s1 <= select_pin;     sel_s2 <= sel_s1;
            sck_s1 <= sclk_pin;       sck_s2 <= sck_s1;
            sck_d  <= sck_s2;
            sdi_s1 <= serial_in_line; sdi_s2 <= sdi_s1;
        end
    end

    // free-running 1 Hz tick divider
    always @(posedge core_clk) begin
        if (!rst_n) begin
            tick_div <= 25'h0000000;
            tick     <= 1'b0;
        end else if (tick_div == TICK_CYCLES[24:0] - 1'b1) begin
            tick_div <= 25'h0000000;
            tick     <= 1'b1;
        end else begin
            tick_div <= tick_div + 1'b1;
            tick     <= 1'b0;
        end
    end

    // second tick after the command byte trips; first may come at once,
    // so the trip lands between one and two seconds
    assign wd_trip = tick & (state == ST_DATA) &
                     (wd_ticks == `SAW_WD_TRIP_TICKS - 2'h1);

    // interface state machine and serial shifter
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE; bit_cnt <= 3'h0; in_shift <= 8'h00;
            out_shift <= 8'h00; rd_mode <= 1'b0; load_pend <= 1'b0;
            addr <= 4'h0; wd_ticks <= 2'h0; wr_valid <= 1'b0;
            wr_word <= 12'h000; serial_out_en <= 1'b0;
            serial_out_line <= 1'b0; wd_abort <= 1'b0;
            write_dropped <= 1'b0;
        end else begin
            wr_valid <= 1'b0;
            wd_abort <= 1'b0;
            if (wr_valid && !wr_ready)
                write_dropped <= 1'b1;  // full fifo loses the byte
            if (!sel_s2) begin
                // select low resets the interface and ends a lock
                state <= ST_IDLE;
                bit_cnt <= 3'h0; load_pend <= 1'b0;
                wd_ticks <= 2'h0; serial_out_en <= 1'b0;
            end else case (state)
                ST_IDLE: begin
                    state   <= ST_CMD;
                    bit_cnt <= 3'h0;
                end
                ST_CMD: if (sck_rise) begin
                    in_shift <= next_byte;
                    bit_cnt  <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        if (next_byte[`SAW_CMD_SA_HI:`SAW_CMD_SA_LO]
                            == `SAW_CMD_SA_VALID) begin
                            state     <= ST_DATA;
                            rd_mode   <= next_byte[`SAW_CMD_RW_BIT];
                            addr      <= next_byte[`SAW_CMD_RA_HI:
                                                   `SAW_CMD_RA_LO];
                            load_pend <= next_byte[`SAW_CMD_RW_BIT];
                            wd_ticks  <= 2'h0;
                        end else
                            state <= ST_IGN;
                    end
                end
                ST_DATA: begin
                    if (wd_trip) begin
                        state         <= ST_LOCK;
                        wd_abort      <= 1'b1;
                        serial_out_en <= 1'b0;
                    end else begin
                        if (tick)
                            wd_ticks <= wd_ticks + 2'h1;
                        if (sck_rise) begin
                            in_shift <= next_byte;
                            bit_cnt  <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                // auto advance wraps past last index
                                if (rd_mode)
                                    load_pend <= 1'b1;
                                else begin
                                    wr_valid <= 1'b1;
                                    wr_word  <= {addr, next_byte};
                                    addr     <= addr + 4'h1;
                                end
                            end
                        end
                        if (sck_fall && rd_mode) begin
                            serial_out_en <= 1'b1;
                            if (load_pend) begin
                                // month then year in one burst
                                out_shift <= regs[addr];
                                serial_out_line <= regs[addr][7];
                                addr      <= addr + 4'h1;
                                load_pend <= 1'b0;
                            end else begin
                                out_shift <= {out_shift[6:0], 1'b0};
                                serial_out_line <= out_shift[6];
                            end
                        end
                    end
                end
                ST_IGN:  state <= ST_IGN;   // wait for select low
                ST_LOCK: state <= ST_LOCK;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // time counters run on ticks unless an access holds them; the
    // tick swallowed in the data phase is never made up, so an abort
    // costs one second plus any command-byte ticks: the trip tick itself counts
    always @(posedge core_clk) begin
        if (!rst_n) begin
            seconds_count   <= 16'h0000;
            counters_frozen <= 1'b0;
        end else begin
            counters_frozen <= sel_s2 &&
                               (state == ST_CMD || state == ST_DATA)
                               && !wd_trip;
            if (tick && (!counters_frozen || wd_trip))
                seconds_count <= seconds_count + 16'h0001;
        end
    end

    // register file takes writes from the fifo
    integer i;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            for (i = 0; i < 16; i = i + 1)
                regs[i] <= `SAW_REG_RESET;
        end else if (fifo_valid && fifo_ready) begin
            regs[fifo_word[11:8]] <= fifo_word[7:0];
        end
    end
endmodule
`default_nettype wire

// ==== test/saw_chk_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module saw_chk #(
    parameter TICK_CYCLES = 200
) (
    input wire logic        core_clk,        // block clock
    input wire logic        rst_n,           // sync reset
    input wire logic        select_pin,      // chip enable
    input wire logic        sclk_pin,        // serial clock
    input wire logic        serial_in_line,  // data in
    input wire logic        serial_out_line, // data out
    input wire logic        serial_out_en,   // out enable
    input wire logic        counters_frozen, // freeze flag
    input wire logic [15:0] seconds_count,   // seconds
    input wire logic        wd_abort,        // trip pulse
    input wire logic        write_dropped    // fifo drop
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] fz_cnt; // cycles spent frozen
    logic        locked; // trip seen, select not yet low
    // freeze length, and lockout that only select low lifts
    always @(posedge core_clk) begin
        if (!rst_n || !counters_frozen)
            fz_cnt <= 32'h0;
        else
            fz_cnt <= fz_cnt + 32'h1;
        if (!rst_n || !select_pin)
            locked <= 1'h0;
        else if (wd_abort)
            locked <= 1'h1;
    end
    frozen_hold_a: assert property (
        counters_frozen && $past(counters_frozen) |-> $stable(seconds_count))
        else $error("seconds moved while frozen");
    idle_release_a: assert property (
        !select_pin [*6] |-> !counters_frozen && !serial_out_en)
        else $error("select low left link busy");
    abort_thaw_a: assert property (
        wd_abort |-> $past(counters_frozen) && !counters_frozen)
        else $error("trip did not thaw");
    abort_pulse_a: assert property (wd_abort |=> !wd_abort)
        else $error("trip pulse too long");
    abort_lock_a: assert property (
        locked |-> !counters_frozen && !serial_out_en)
        else $error("link active after trip");
    // the freeze also spans the command byte, hence the slack
    trip_window_a: assert property (
        wd_abort |-> fz_cnt >= TICK_CYCLES &&
                     fz_cnt <= 2 * TICK_CYCLES + 200)
        else $error("trip outside window");
    step_one_a: assert property (
        seconds_count != $past(seconds_count) |->
        seconds_count == $past(seconds_count) + 16'h1)
        else $error("seconds jumped");
    drive_frozen_a: assert property (
        $rose(serial_out_en) |-> counters_frozen)
        else $error("output driven outside access");
    cover property (wd_abort);
    cover property ($rose(serial_out_en));
    cover property ($rose(counters_frozen));
endmodule
bind saw_watchdog saw_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .select_pin(select_pin),
    .sclk_pin(sclk_pin), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line), .serial_out_en(serial_out_en),
    .counters_frozen(counters_frozen), .seconds_count(seconds_count),
    .wd_abort(wd_abort), .write_dropped(write_dropped));
`default_nettype wire

// ==== test/saw_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module saw_host (
    input  wire logic       core_clk,        // bench clock
    output var  logic       select_pin,      // chip enable
    output var  logic       sclk_pin,        // still outside frames
    output var  logic       serial_in_line,  // data to device
    input  wire logic       serial_out_line, // data from device
    input  wire logic       serial_out_en,   // device drives out
    output var  logic [7:0] rx_byte,         // last byte read
    output var  logic       rx_stb           // pulse per read byte
);
    // idle bus at time zero
    initial begin
        select_pin = 1'h0;
        sclk_pin = 1'h0;
        serial_in_line = 1'h0;
        rx_byte = 8'h0;
        rx_stb = 1'h0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // the device needs a few cycles to see select through its syncs
    task automatic start;
        select_pin = 1'h1;
        wait_n(8);
    endtask
    // sdi flips at frame end so a stale level never looks valid
    task automatic stop;
        select_pin = 1'h0;
        serial_in_line = ~serial_in_line;
        wait_n(8);
    endtask
    // 400 ns bit; data read late in the high phase, as output lags
    task automatic xbyte(input logic [7:0] tx, input logic rd);
        logic [7:0] sh;
        sh = 8'h0;
        for (int i = 7; i >= 0; i--) begin
            serial_in_line = tx[i];
            wait_n(4);
            sclk_pin = 1'h1;
            wait_n(4);
            // an undriven output reads inverted, so a late enable shows
            sh = {sh[6:0], serial_out_en ? serial_out_line
                                         : ~serial_out_line};
            sclk_pin = 1'h0;
        end
        rx_byte = sh;
        rx_stb = rd;
        wait_n(1);
        rx_stb = 1'h0;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_saw_watchdog.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_saw_watchdog;
    localparam TICKS = 2000; // short tick keeps the run brief
    logic core_clk = 1'h0, rst_n = 1'h0;
    logic select_pin, sclk_pin, serial_in_line, serial_out_line;
    logic serial_out_en, counters_frozen, wd_abort, write_dropped;
    logic rx_stb;
    logic [15:0] seconds_count;
    logic [7:0] rx_byte, e;
    logic [7:0] exp_q[$]; // bytes the reads must return
    int failures = 0, checks = 0;
    always #25 core_clk = ~core_clk;
    saw_watchdog #(.TICK_CYCLES(TICKS)) u_dut (.core_clk(core_clk),
        .rst_n(rst_n), .select_pin(select_pin), .sclk_pin(sclk_pin),
        .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
        .serial_out_en(serial_out_en), .counters_frozen(counters_frozen),
        .seconds_count(seconds_count), .wd_abort(wd_abort),
        .write_dropped(write_dropped));
    saw_host u_host (.core_clk(core_clk), .select_pin(select_pin),
        .sclk_pin(sclk_pin), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line), .rx_byte(rx_byte),
        .serial_out_en(serial_out_en),
        .rx_stb(rx_stb));
    task automatic chk(input string nm, input logic [15:0] x, y);
        checks++;
        if (y !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // each read byte is matched against the oldest note
    always @(posedge rx_stb) begin
        e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
        chk("read byte", {8'h0, e}, {8'h0, rx_byte});
    end
    initial begin
        logic [7:0] m, y, mm;
        logic [3:0] st;
        logic [15:0] s0;
        int n;
        n = $urandom(88);
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        // write then burst-read month/year, and across the wrap
        for (int k = 0; k < 2; k++) begin
            st = k ? 4'hf : 4'h7;
            m = $urandom;
            y = $urandom;
            if (k == 0)
                mm = m;
            u_host.start();
            u_host.xbyte({4'h1, st}, 1'h0);
            chk("frozen", 16'h1, counters_frozen);
            u_host.xbyte(m, 1'h0);
            u_host.xbyte(y, 1'h0);
            u_host.stop();
            chk("frozen", 16'h0, counters_frozen);
            exp_q.push_back(m);
            exp_q.push_back(y);
            u_host.start();
            u_host.xbyte({4'h9, st}, 1'h0);
            u_host.xbyte(8'h0, 1'h1);
            u_host.xbyte(8'h0, 1'h1);
            u_host.stop();
        end
        // every wrong sub-address, direction from its low bit, is ignored
        for (int s = 0; s < 8; s++) begin
            if (s == 1)
                continue;
            u_host.start();
            u_host.xbyte({s[0], s[2:0], 4'h7}, 1'h0);
            u_host.xbyte(~mm, 1'h0);
            chk("frozen", 16'h0, counters_frozen);
            chk("out en", 16'h0, serial_out_en);
            u_host.stop();
        end
        exp_q.push_back(mm);
        u_host.start();
        u_host.xbyte(8'h97, 1'h0);
        u_host.xbyte(8'h0, 1'h1);
        u_host.stop();
        // stuck access: start just after a tick so the loss is exact
        s0 = seconds_count;
        n = 0;
        while (seconds_count === s0 && n < 2 * TICKS) begin
            @(negedge core_clk);
            n++;
        end
        chk("tick seen", 16'h1, n < 2 * TICKS);
        s0 = seconds_count;
        u_host.start();
        u_host.xbyte(8'h97, 1'h0);
        n = 0;
        while (wd_abort !== 1'h1 && n < 3 * TICKS) begin
            @(negedge core_clk);
            n++;
        end
        chk("trip seen", 16'h1, n < 3 * TICKS);
        chk("trip late", 16'h1, n >= TICKS && n <= 2 * TICKS + 8);
        chk("frozen", 16'h0, counters_frozen);
        chk("seconds", s0 + 16'h1, seconds_count);
        u_host.xbyte(8'h97, 1'h0);
        chk("frozen", 16'h0, counters_frozen);
        chk("out en", 16'h0, serial_out_en);
        u_host.stop();
        exp_q.push_back(mm);
        u_host.start();
        u_host.xbyte(8'h97, 1'h0);
        u_host.xbyte(8'h0, 1'h1);
        u_host.stop();
        chk("queue", 16'h0, exp_q.size());
        chk("dropped", 16'h0, write_dropped);
        test_done();
    end
endmodule
`default_nettype wire
